// ==== src/sws_map.vh ====
/*
  Register offsets, field positions, reset values and timing constants of the
  setpoint waveform sequencer.
  Assumes a 100 MHz clock and an APB slave with 32-bit data.
*/
// Operation
// - Trapezoid steps rise, top, fall, base; each phase timed 0.1 ms to 36e6 ms.
// - Base equals offset, top equals offset plus amplitude, capped at nominal.
// - Cranking curve drives voltage only; five points each ramp start to end.
// - Cranking curve repeats 0 to 999 times; zero repeats endlessly.
// - A pause of configurable time follows every cranking cycle before repeating.
// - Static start/end voltage holds before and after a cranking run.
// - Ninety-nine segment slots, all aimed at one quantity, voltage or current.
// - Arbitrary run covers a contiguous block from first to last index.
// - Segment block repeats 1 to 999 times; zero repeats endlessly.
// - Segment output is linear DC ramp plus swept-amplitude swept-frequency sine.
// - Start and end sine amplitudes lie between zero and half nominal.
// - DC start and end stay within amplitude and nominal minus amplitude.
// - Frequencies span 0 to 10000 Hz; both zero means DC ramp only.
// - Sine starts at a 0 to 359 degree angle in one degree steps.
// - Each segment has its own duration of 0.1 ms to 36e6 ms.
// - Reject a segment whose frequency change per second is below 9.3.
// - Reject a segment whose amplitude change is too small for its duration.
// - Sine periods equal time times frequency; partial periods run as they fall.
// - Any alarm stops the waveform at once, turns output off, reports.
// - Output quantised to about 52428 steps; slow changes form a staircase.
`ifndef SWS_MAP_VH
`define SWS_MAP_VH
`define SWS_CTRL        12'h000
`define SWS_STATUS      12'h004
`define SWS_TRAP_AMP    12'h008
`define SWS_TRAP_OFS    12'h00C
`define SWS_TRAP_T0     12'h010
`define SWS_CRK_V0      12'h020
`define SWS_CRK_T0      12'h034
`define SWS_CRK_CYC     12'h048
`define SWS_CRK_PAUSE   12'h04C
`define SWS_CRK_STATIC  12'h050
`define SWS_GLOB_I      12'h054
`define SWS_GLOB_P      12'h058
`define SWS_ARB_BLOCK   12'h05C
`define SWS_ARB_CYC     12'h060
`define SWS_NOMINAL     12'h064
`define SWS_SETPOINT    12'h068
`define SWS_SEG_SEL     12'h06C
`define SWS_SEG_W0      12'h070
`define SWS_CTRL_RUN    0
`define SWS_CTRL_STOP   1
`define SWS_CTRL_MODE   3:2
`define SWS_CTRL_TGT    4
`define SWS_CTRL_OUTEN  5
`define SWS_CTRL_ACLR   6
`define SWS_MODE_TRAP   2'h1
`define SWS_MODE_CRANK  2'h2
`define SWS_MODE_ARB    2'h3
`define SWS_SEGS        99
`define SWS_MAXCYC      10'd999
`define SWS_FULL_SCALE  16'hCCCC
`define SWS_TICK_NS     100
`define SWS_CLK_NS      10
`define SWS_TICK_CYC    (`SWS_TICK_NS / `SWS_CLK_NS)
`define SWS_DF_MIN_X10  93
`define SWS_DA_MIN_PER_S 1
`define SWS_ANG_MAX     9'd359
`define SWS_FREQ_MAX    14'd10000
`endif

// ==== src/sws_sequencer.v ====
/*
  Setpoint waveform sequencer: trapezoid, five-point cranking curve and an
  arbitrary generator of up to 99 DC+sine segments, with an APB register file.
  Assumes one 100 MHz clock, asynchronous active-low reset, an APB master,
  and an alarm input from outside the clock domain. Times are counted in
  0.1 ms units; frequencies in Hz; angles in degrees; levels in 16-bit codes.
*/
`timescale 1ns/1ps
`include "sws_map.vh"
module sws_sequencer #(
  parameter TICK_CYC = 10000,
  parameter NSEG     = 99
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        alarm_in,
  output reg  [15:0] volt_set,
  output reg  [15:0] curr_set,
  output reg  [15:0] pwr_set,
  output reg         output_on,
  output reg         running,
  output reg         alarm_out,
  output reg         seg_reject
);
  localparam ST_IDLE  = 5'b00001;
  localparam ST_RUN   = 5'b00010;
  localparam ST_PAUSE = 5'b00100;
  localparam ST_DONE  = 5'b01000;
  localparam ST_ALARM = 5'b10000;

  // Segment memory: amp start, amp end, f start, f end, angle, dc start, dc end, time.
  reg [15:0] m_acs [0:NSEG-1];
  reg [15:0] m_ace [0:NSEG-1];
  reg [13:0] m_fs  [0:NSEG-1];
  reg [13:0] m_fe  [0:NSEG-1];
  reg [8:0]  m_ang [0:NSEG-1];
  reg [15:0] m_dcs [0:NSEG-1];
  reg [15:0] m_dce [0:NSEG-1];
  reg [31:0] m_tim [0:NSEG-1];
  reg [15:0] crk_v0 [0:4];
  reg [15:0] crk_v1 [0:4];
  reg [31:0] crk_t  [0:4];
  reg [31:0] trap_t [0:3];

  reg [6:0]  ctrl_q;
  reg [15:0] amp_q, ofs_q, nom_q, stat_v_q, glob_i_q, glob_p_q;
  reg [9:0]  crk_cyc_q, arb_cyc_q;
  reg [31:0] pause_q;
  reg [6:0]  first_q, last_q, sel_q;
  reg [4:0]  st_q;
  reg [6:0]  idx_q;
  reg [9:0]  cyc_q;
  reg [31:0] tcnt_q, tlen_q;
  reg [15:0] v0_q, v1_q, a0_q, a1_q;
  reg [13:0] f0_q, f1_q;
  reg [31:0] phase_q;
  reg [31:0] tick_q;
  reg        al_s1_q, al_s2_q;
  integer    k;

  wire tick     = (tick_q == TICK_CYC - 1);
  wire [1:0] md = ctrl_q[3:2];
  wire wr       = psel & penable & pwrite;
  wire [6:0] sx = (sel_q < NSEG) ? sel_q : 7'd0;

  // Alarm input passes a two-flop synchroniser before use.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      al_s1_q <= 1'b0;
      al_s2_q <= 1'b0;
    end else begin
      al_s1_q <= alarm_in;
      al_s2_q <= al_s1_q;
    end
  end

  // Sample tick divider; all waveform updates step on it.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      tick_q <= 32'h0;
    else
      tick_q <= tick ? 32'h0 : tick_q + 32'h1;
  end

  // APB register writes; segment words addressed through a select register.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 7'h00;
      amp_q <= 16'h0000;
      ofs_q <= 16'h0000;
      nom_q <= `SWS_FULL_SCALE;
      stat_v_q <= 16'h0000;
      glob_i_q <= 16'h0000;
      glob_p_q <= 16'h0000;
      crk_cyc_q <= 10'h001;
      arb_cyc_q <= 10'h001;
      pause_q <= 32'h1;
      first_q <= 7'h01;
      last_q <= 7'h01;
      sel_q <= 7'h00;
    end else begin
      ctrl_q[0] <= 1'b0;
      ctrl_q[1] <= 1'b0;
      ctrl_q[6] <= 1'b0;
      if (wr && psel) begin
        case (paddr)
          `SWS_CTRL:       ctrl_q <= pwdata[6:0];
          `SWS_TRAP_AMP:   amp_q <= (pwdata[15:0] > nom_q) ? nom_q : pwdata[15:0];
          `SWS_TRAP_OFS:   ofs_q <= (pwdata[15:0] > nom_q - amp_q) ? nom_q - amp_q
                                    : pwdata[15:0];
          `SWS_CRK_CYC:    crk_cyc_q <= (pwdata[9:0] > `SWS_MAXCYC) ? `SWS_MAXCYC
                                        : pwdata[9:0];
          `SWS_CRK_PAUSE:  pause_q <= (pwdata == 32'h0) ? 32'h1 : pwdata;
          `SWS_CRK_STATIC: stat_v_q <= pwdata[15:0];
          `SWS_GLOB_I:     glob_i_q <= pwdata[15:0];
          `SWS_GLOB_P:     glob_p_q <= pwdata[15:0];
          `SWS_ARB_BLOCK:  if (pwdata[6:0] >= 7'd1 && pwdata[6:0] <= pwdata[14:8] &&
                               pwdata[14:8] <= `SWS_SEGS) begin
                             first_q <= pwdata[6:0];
                             last_q  <= pwdata[14:8];
                           end
          `SWS_ARB_CYC:    arb_cyc_q <= (pwdata[9:0] > `SWS_MAXCYC) ? `SWS_MAXCYC
                                        : pwdata[9:0];
          `SWS_NOMINAL:    nom_q <= pwdata[15:0];
          `SWS_SEG_SEL:    sel_q <= pwdata[6:0];
          default: ;
        endcase
      end
    end
  end

  // Array writes: trapezoid times, cranking points and segment words.
  always @(posedge clock) begin
    if (wr) begin
      for (k = 0; k < 4; k = k + 1)
        if (paddr == `SWS_TRAP_T0 + 4*k)
          trap_t[k] <= (pwdata == 32'h0) ? 32'h1 : pwdata;
      for (k = 0; k < 5; k = k + 1) begin
        if (paddr == `SWS_CRK_V0 + 4*k) begin
          crk_v0[k] <= pwdata[15:0];
          crk_v1[k] <= pwdata[31:16];
        end
        if (paddr == `SWS_CRK_T0 + 4*k)
          crk_t[k] <= (pwdata == 32'h0) ? 32'h1 : pwdata;
      end
      case (paddr)
        `SWS_SEG_W0: begin
          m_acs[sx] <= (pwdata[15:0] > nom_q >> 1) ? nom_q >> 1 : pwdata[15:0];
          m_ace[sx] <= (pwdata[31:16] > nom_q >> 1) ? nom_q >> 1 : pwdata[31:16];
        end
        `SWS_SEG_W0 + 12'h4: begin
          m_fs[sx] <= (pwdata[13:0] > `SWS_FREQ_MAX) ? `SWS_FREQ_MAX : pwdata[13:0];
          m_fe[sx] <= (pwdata[29:16] > `SWS_FREQ_MAX) ? `SWS_FREQ_MAX : pwdata[29:16];
        end
        `SWS_SEG_W0 + 12'h8: m_ang[sx] <= (pwdata[8:0] > `SWS_ANG_MAX) ? `SWS_ANG_MAX
                                           : pwdata[8:0];
        `SWS_SEG_W0 + 12'hC: begin
          m_dcs[sx] <= pwdata[15:0];
          m_dce[sx] <= pwdata[31:16];
        end
        `SWS_SEG_W0 + 12'h10: m_tim[sx] <= (pwdata == 32'h0) ? 32'h1 : pwdata;
        default: ;
      endcase
    end
  end

  // Segment checks: DC window, sweep rate and amplitude change per time.
  wire [15:0] c_acs = m_acs[idx_q];
  wire [15:0] c_ace = m_ace[idx_q];
  wire [15:0] c_dcs = m_dcs[idx_q];
  wire [15:0] c_dce = m_dce[idx_q];
  wire [13:0] c_fs  = m_fs[idx_q];
  wire [13:0] c_fe  = m_fe[idx_q];
  wire [31:0] c_tim = m_tim[idx_q];
  wire [13:0] dfr   = (c_fe > c_fs) ? c_fe - c_fs : c_fs - c_fe;
  wire [15:0] dam   = (c_ace > c_acs) ? c_ace - c_acs : c_acs - c_ace;
  wire [63:0] df_lhs = {50'h0, dfr} * 64'd100000;
  wire [63:0] df_rhs = {32'h0, c_tim} * 64'd93;
  wire [63:0] da_lhs = {48'h0, dam} * 64'd10000;
  wire dc_bad = (c_dcs < c_acs) || (c_dcs > nom_q - c_acs) ||
                (c_dce < c_ace) || (c_dce > nom_q - c_ace);
  wire df_bad = (dfr != 14'h0) && (df_lhs < df_rhs);
  wire da_bad = (dam != 16'h0) && (da_lhs < {32'h0, c_tim});
  wire seg_bad = dc_bad | df_bad | da_bad;

  // Linear interpolation from v0 to v1 across the present phase.
  wire [47:0] num  = (v1_q >= v0_q) ? {32'h0, v1_q - v0_q} * {16'h0, tcnt_q}
                                    : {32'h0, v0_q - v1_q} * {16'h0, tcnt_q};
  wire [47:0] step = num / {16'h0, tlen_q};
  wire [15:0] lin  = (v1_q >= v0_q) ? v0_q + step[15:0] : v0_q - step[15:0];
  wire [47:0] anum = (a1_q >= a0_q) ? {32'h0, a1_q - a0_q} * {16'h0, tcnt_q}
                                    : {32'h0, a0_q - a1_q} * {16'h0, tcnt_q};
  wire [47:0] astp = anum / {16'h0, tlen_q};
  wire [15:0] aval = (a1_q >= a0_q) ? a0_q + astp[15:0] : a0_q - astp[15:0];
  wire [47:0] fnum = (f1_q >= f0_q) ? {34'h0, f1_q - f0_q} * {16'h0, tcnt_q}
                                    : {34'h0, f0_q - f1_q} * {16'h0, tcnt_q};
  wire [47:0] fstp = fnum / {16'h0, tlen_q};
  wire [13:0] fval = (f1_q >= f0_q) ? f0_q + fstp[13:0] : f0_q - fstp[13:0];

  // Sine by parabolic approximation of the phase accumulator top bits.
  wire [15:0] ph    = phase_q[31:16];
  wire [14:0] half  = ph[14:0];
  wire [29:0] para  = {15'h0, half} * {15'h0, 15'h7FFF - half};
  wire [15:0] sinm  = para[27:12]; // Crest of 2^28 scaled to a full 16-bit sine.
  wire [31:0] acm   = {16'h0, aval} * {16'h0, sinm};
  wire [15:0] acv   = acm[31:16];
  wire        sine_on = (f0_q != 14'h0) || (f1_q != 14'h0);
  wire [16:0] sum_p = {1'b0, lin} + {1'b0, acv};
  wire [15:0] wave  = !sine_on ? lin : ph[15] ? lin - acv
                     : (sum_p[16] ? 16'hFFFF : sum_p[15:0]);
  // Phase increment per tick: f * 2^32 / 10000 ticks per second.
  wire [47:0] pinc  = {34'h0, fval} * 48'd429497;

  wire start = ctrl_q[0];
  wire stop  = ctrl_q[1];
  wire last_phase = (md == `SWS_MODE_TRAP) ? (idx_q == 7'd3)
                  : (md == `SWS_MODE_CRANK) ? (idx_q == 7'd4) : (idx_q == last_q - 7'd1);
  wire [9:0] cyc_lim = (md == `SWS_MODE_CRANK) ? crk_cyc_q : arb_cyc_q;
  wire more_cyc = (cyc_lim == 10'h0) || (cyc_q + 10'h1 < cyc_lim);

  // Sequencer state machine; loads each phase's parameters at its start.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      idx_q <= 7'h0;
      cyc_q <= 10'h0;
      tcnt_q <= 32'h0;
      tlen_q <= 32'h1;
      v0_q <= 16'h0;
      v1_q <= 16'h0;
      a0_q <= 16'h0;
      a1_q <= 16'h0;
      f0_q <= 14'h0;
      f1_q <= 14'h0;
      phase_q <= 32'h0;
      seg_reject <= 1'b0;
      alarm_out <= 1'b0;
    end else if (al_s2_q) begin
      st_q <= ST_ALARM;
      alarm_out <= 1'b1;
    end else begin
      if (ctrl_q[6]) alarm_out <= 1'b0;
      case (st_q)
        ST_IDLE, ST_DONE, ST_ALARM: begin
          if (start && !(st_q == ST_ALARM && alarm_out)) begin
            st_q <= ST_RUN;
            cyc_q <= 10'h0;
            tcnt_q <= 32'h0;
            seg_reject <= 1'b0;
            idx_q <= (md == `SWS_MODE_ARB) ? first_q - 7'd1 : 7'h0;
            tlen_q <= 32'h0;
          end
        end
        ST_RUN: begin
          if (stop) st_q <= ST_DONE;
          else if (tlen_q == 32'h0) begin
            // Phase start: latch parameters so later edits wait a segment.
            tcnt_q <= 32'h0;
            case (md)
              `SWS_MODE_TRAP: begin
                tlen_q <= trap_t[idx_q[1:0]]; f0_q <= 14'h0; f1_q <= 14'h0;
                a0_q <= 16'h0; a1_q <= 16'h0;
                v0_q <= (idx_q == 7'd0 || idx_q == 7'd3) ? ofs_q : ofs_q + amp_q;
                v1_q <= (idx_q == 7'd1 || idx_q == 7'd0) ? ofs_q + amp_q : ofs_q;
              end
              `SWS_MODE_CRANK: begin
                tlen_q <= crk_t[idx_q[2:0]]; f0_q <= 14'h0; f1_q <= 14'h0;
                a0_q <= 16'h0; a1_q <= 16'h0;
                v0_q <= crk_v0[idx_q[2:0]]; v1_q <= crk_v1[idx_q[2:0]];
              end
              default: begin
                if (seg_bad) begin
                  seg_reject <= 1'b1; st_q <= ST_DONE;
                end
                tlen_q <= c_tim;
                v0_q <= c_dcs;
                v1_q <= c_dce;
                a0_q <= c_acs;
                a1_q <= c_ace;
                f0_q <= c_fs;
                f1_q <= c_fe;
                phase_q <= {16'h0, 16'h0} + ({23'h0, m_ang[idx_q]} * 32'd11930465);
              end
            endcase
          end else if (tick) begin
            phase_q <= phase_q + pinc[31:0];
            if (tcnt_q + 32'h1 >= tlen_q) begin
              tlen_q <= 32'h0;
              if (!last_phase) idx_q <= idx_q + 7'd1;
              else begin
                idx_q <= (md == `SWS_MODE_ARB) ? first_q - 7'd1 : 7'h0;
                if (!more_cyc) st_q <= ST_DONE;
                else begin
                  cyc_q <= cyc_q + 10'h1;
                  if (md == `SWS_MODE_CRANK) st_q <= ST_PAUSE;
                end
              end
            end else tcnt_q <= tcnt_q + 32'h1;
          end
        end
        ST_PAUSE: begin
          if (stop) st_q <= ST_DONE;
          else if (tick) begin
            if (tcnt_q + 32'h1 >= pause_q) begin
              st_q <= ST_RUN; tcnt_q <= 32'h0;
            end else tcnt_q <= tcnt_q + 32'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Set-value outputs; voltage and current update only on the sample tick, power every clock.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      volt_set <= 16'h0;
      curr_set <= 16'h0;
      pwr_set <= 16'h0;
      output_on <= 1'b0;
      running <= 1'b0;
    end else begin
      running <= (st_q == ST_RUN) || (st_q == ST_PAUSE);
      output_on <= (st_q != ST_ALARM) && ctrl_q[5] && !al_s2_q;
      pwr_set <= glob_p_q;
      if (tick) begin
        if (st_q == ST_RUN && tlen_q != 32'h0 && md != 2'h0) begin
          // Arbitrary mode drives either voltage or current, never both.
          if (md == `SWS_MODE_ARB && ctrl_q[4]) begin
            curr_set <= wave; volt_set <= stat_v_q;
          end else begin
            volt_set <= (md == `SWS_MODE_ARB) ? wave : lin;
            curr_set <= glob_i_q;
          end
        end else if (st_q != ST_RUN) begin
          volt_set <= stat_v_q;
          curr_set <= glob_i_q;
        end
      end
    end
  end

  // APB read path and handshake; one wait-free access phase.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `SWS_SEG_W0 + 12'h10);
      if (psel && !penable) begin
        case (paddr)
          `SWS_CTRL:      prdata <= {25'h0, ctrl_q};
          `SWS_STATUS:    prdata <= {12'h0, cyc_q, idx_q, alarm_out, seg_reject, running};
          `SWS_TRAP_AMP:  prdata <= {16'h0, amp_q};
          `SWS_TRAP_OFS:  prdata <= {16'h0, ofs_q};
          `SWS_CRK_CYC:   prdata <= {22'h0, crk_cyc_q};
          `SWS_ARB_BLOCK: prdata <= {17'h0, last_q, 1'b0, first_q};
          `SWS_ARB_CYC:   prdata <= {22'h0, arb_cyc_q};
          `SWS_NOMINAL:   prdata <= {16'h0, nom_q};
          `SWS_SETPOINT:  prdata <= {curr_set, volt_set};
          `SWS_SEG_SEL:   prdata <= {25'h0, sel_q};
          default:        prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule // sws_sequencer

// ==== tb/sws_asserts.sv ====
/* Checker of bus timing, alarm stop and level cap at the sequencer ports.
   Assumes it is bound to sws_sequencer in its single clock domain. */
`timescale 1ns/1ps
module sws_asserts (
  input logic        clock,
  input logic        rst_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  input logic        alarm_in,
  input logic [15:0] volt_set,
  input logic        output_on,
  input logic        running,
  input logic        alarm_out
);
  logic        wr_ctrl;
  logic [15:0] nom_q;
  // Decodes control writes; the nominal shadow starts open so no cap applies unset.
  assign wr_ctrl = psel && penable && pwrite && paddr == 12'h000;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) nom_q <= 16'hFFFF;
    else if (psel && penable && pwrite && paddr == 12'h064) nom_q <= pwdata[15:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Bus answers, alarm behaviour, level cap and run control.
  chk_pready_zero: assert property (psel && penable |-> pready)
    else $error("pready low in access phase.");
  chk_slverr_high: assert property (pready && paddr > 12'h080 |-> pslverr)
    else $error("no error above the map.");
  chk_slverr_low: assert property (pready && paddr <= 12'h080 |-> !pslverr)
    else $error("error inside the map.");
  chk_alarm_flag: assert property (alarm_in [*5] |-> alarm_out)
    else $error("alarm not reported.");
  chk_alarm_halt: assert property (alarm_in [*5] |-> !running && !output_on)
    else $error("alarm did not stop output.");
  chk_alarm_sticky: assert property (alarm_out && !$past(wr_ctrl && pwdata[6]) |=> alarm_out)
    else $error("alarm flag dropped alone.");
  chk_nominal_cap: assert property (running |-> volt_set <= nom_q)
    else $error("level above nominal.");
  chk_stop_halt: assert property (wr_ctrl && pwdata[1] |-> ##[1:3] !running)
    else $error("stop ignored.");
endmodule // sws_asserts

bind sws_sequencer sws_asserts u_sws_asserts (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .alarm_in(alarm_in), .volt_set(volt_set), .output_on(output_on),
  .running(running), .alarm_out(alarm_out));

// ==== tb/sws_stage_model.sv ====
/* Power stage model: applies the voltage set value and tracks its peak.
   Assumes the sequencer's clock and reset; clr restarts the peak. */
`timescale 1ns/1ps
module sws_stage_model (
  input  logic        clock,
  input  logic        rst_n,
  input  logic        clr,
  input  logic        output_on,
  input  logic [15:0] volt_set,
  output logic [15:0] app_v,
  output logic [15:0] peak_v
);
  // A switched-off stage delivers nothing, whatever the set value says.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      app_v  <= 16'h0000;
      peak_v <= 16'h0000;
    end else begin
      app_v <= output_on ? volt_set : 16'h0000;
      if (clr) peak_v <= 16'h0000;
      else if (output_on && volt_set > peak_v) peak_v <= volt_set;
    end
  end
endmodule // sws_stage_model

// ==== tb/sws_sequencer_tb.sv ====
/* Self-checking bench of the setpoint sequencer driven over APB.
   Assumes sws_sequencer, the stage model and the bound checker. */
`timescale 1ns/1ps
module sws_sequencer_tb;
  logic        clock, rst_n, psel, penable, pwrite, alarm_in, clr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, output_on, running, alarm_out, seg_reject;
  logic [15:0] volt_set, curr_set, pwr_set, app_v, peak_v;
  int          miscompares, compares, cyc_cnt;
  sws_sequencer #(.TICK_CYC(4), .NSEG(99)) u_sws_sequencer (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alarm_in(alarm_in), .volt_set(volt_set), .curr_set(curr_set),
    .pwr_set(pwr_set), .output_on(output_on), .running(running),
    .alarm_out(alarm_out), .seg_reject(seg_reject));
  sws_stage_model u_sws_stage_model (.clock(clock), .rst_n(rst_n), .clr(clr),
    .output_on(output_on), .volt_set(volt_set), .app_v(app_v), .peak_v(peak_v));
  // Makes the 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Cuts a hung run short.
  always @(posedge clock) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000) begin
      miscompares++;
      test_done();
    end
  end
  task test_done;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // One APB transfer, held until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Selects the mode first, then starts it.
  task go(input logic [31:0] c);
    clr <= 1'b1;
    apb(1'b1, 12'h000, c & 32'hFFFF_FFFE);
    apb(1'b1, 12'h000, c);
    clr <= 1'b0;
  endtask
  task stop_run;
    apb(1'b1, 12'h000, 32'h0000_0022);
    repeat (3) @(posedge clock);
    chk(running === 1'b0, "run did not stop");
  endtask
  task wait_v(input logic sel, input logic [15:0] e, input string m);
    int n;
    n = 0;
    while ((sel ? curr_set : volt_set) !== e && n < 800) begin
      @(posedge clock);
      n++;
    end
    chk((sel ? curr_set : volt_set) === e, m);
  endtask
  task t_regs;
    apb(1'b1, 12'h064, 32'h0000_0400);
    apb(1'b0, 12'h064, 32'h0);
    chk(rd[15:0] === 16'h0400 && err === 1'b0, "nominal readback");
    apb(1'b0, 12'h0FC, 32'h0);
    chk(err === 1'b1, "unmapped read accepted");
  endtask
  // Trapezoid whose offset must be pulled down to nominal minus amplitude.
  task t_trap;
    int k;
    apb(1'b1, 12'h008, 32'h0000_0300);
    apb(1'b1, 12'h00C, 32'h0000_0200);
    for (k = 0; k < 4; k++) apb(1'b1, 12'h010 + 12'(k * 4), 32'(2 + k % 2));
    go(32'h0000_0025);
    wait_v(1'b0, 16'h0400, "top not reached");
    repeat (6) @(posedge clock);
    chk(volt_set === 16'h0400, "top left early");
    wait_v(1'b0, 16'h0100, "base not reached");
    chk(peak_v <= 16'h0400, "above nominal");
    stop_run();
  endtask
  task crank_cfg(input logic [31:0] cyc);
    int k;
    for (k = 0; k < 5; k++) begin
      apb(1'b1, 12'h020 + 12'(k * 4), {16'((k + 1) * 128), 16'(k * 128)});
      apb(1'b1, 12'h034 + 12'(k * 4), 32'h1);
    end
    apb(1'b1, 12'h048, cyc);
    apb(1'b1, 12'h04C, 32'h3);
    apb(1'b1, 12'h050, 32'h0050);
    apb(1'b1, 12'h054, 32'h0111);
    apb(1'b1, 12'h058, 32'h0222);
    go(32'h0000_0029);
  endtask
  // Two ramp cycles of 20 clocks each and a pause of 12 clocks between them.
  task t_crank;
    int n;
    crank_cfg(32'h2);
    repeat (8) @(posedge clock);
    chk(curr_set === 16'h0111 && pwr_set === 16'h0222, "globals lost");
    n = 0;
    while (running !== 1'b0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    chk(n >= 44 && n < 90, "run length wrong");
    repeat (5) @(posedge clock);
    chk(volt_set === 16'h0050 && curr_set === 16'h0111, "static lost");
    chk(peak_v >= 16'h0200 && peak_v <= 16'h0280, "ramp off");
  endtask
  task seg_cfg(input logic [31:0] slot, amp, freq, ang, dc, tm, blk, cyc, ctl);
    apb(1'b1, 12'h06C, slot);
    apb(1'b1, 12'h070, amp);
    apb(1'b1, 12'h074, freq);
    apb(1'b1, 12'h078, ang);
    apb(1'b1, 12'h07C, dc);
    apb(1'b1, 12'h080, tm);
    apb(1'b1, 12'h05C, blk);
    apb(1'b1, 12'h060, cyc);
    go(ctl);
  endtask
  task t_arb;
    seg_cfg(32'h0, 32'h0010_0000, 32'h0, 32'h0, 32'h0123_0123, 32'h2, 32'h0101, 32'h0, 32'h3D);
    wait_v(1'b1, 16'h0123, "DC level wrong");
    repeat (100) @(posedge clock);
    chk(running === 1'b1 && seg_reject === 1'b0, "endless block ended");
    stop_run();
  endtask
  // A 1 Hz to 11 Hz sweep over 5 s is too slow.
  task t_reject;
    seg_cfg(32'h1, 32'h0010_0000, 32'h000B_0001, 32'h0, 32'h0123_0123, 32'd50000, 32'h0202,
            32'h1, 32'h3D);
    repeat (20) @(posedge clock);
    chk(seg_reject === 1'b1, "slow sweep accepted");
    stop_run();
    // An amplitude step of one code over 2 s is too small.
    seg_cfg(32'h1, 32'h0001_0000, 32'h0, 32'h0, 32'h0123_0123, 32'd20000, 32'h0202,
            32'h1, 32'h3D);
    repeat (20) @(posedge clock);
    chk(seg_reject === 1'b1, "tiny amplitude change accepted");
    stop_run();
  endtask
  // A 2500 Hz sine of amplitude 0x100 on 0x200, starting at 180 degrees.
  task t_sine;
    logic [15:0] lo, fst;
    apb(1'b1, 12'h050, 32'h0000_0200);
    seg_cfg(32'h2, 32'h0100_0100, 32'h09C4_09C4, 32'd180, 32'h0200_0200, 32'h8, 32'h0303,
            32'h1, 32'h2D);
    lo = 16'hFFFF;
    fst = 16'h0200;
    repeat (60) begin
      @(posedge clock);
      if (volt_set < lo) lo = volt_set;
      if (fst === 16'h0200) fst = volt_set;
    end
    chk(fst < 16'h0200, "first half wave not negative");
    chk(peak_v >= 16'h02F0 && peak_v <= 16'h0300, "sine crest off");
    chk(lo >= 16'h0100 && lo <= 16'h0110, "sine trough off");
  endtask
  task t_alarm;
    crank_cfg(32'h0);
    repeat (80) @(posedge clock);
    chk(running === 1'b1, "endless curve ended");
    alarm_in <= 1'b1;
    repeat (8) @(posedge clock);
    chk(running === 1'b0 && app_v === 16'h0 && alarm_out === 1'b1, "no stop");
    alarm_in <= 1'b0;
    repeat (4) @(posedge clock);
    apb(1'b1, 12'h000, 32'h0000_0040);
    repeat (2) @(posedge clock);
    chk(alarm_out === 1'b0, "alarm not cleared");
  endtask
  // Resets for 20 cycles, then runs every scenario.
  initial begin
    {psel, penable, pwrite, alarm_in, clr, paddr, pwdata} = '0;
    {miscompares, compares, cyc_cnt} = '0;
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_trap();
    t_crank();
    t_arb();
    t_reject();
    t_sine();
    t_alarm();
    test_done();
  end
endmodule // sws_sequencer_tb
